// *** design/slpc_ctrl.sv ***
// Host-side power controller for a three-channel line transceiver, with APB registers.
// Assumes the transceiver pins are wired directly; detect and receiver outputs are asynchronous.
`default_nettype none
module slpc_ctrl #(
  parameter int WAKE_CYCLES = slpc_pkg::WAKE_CYCLES,
  parameter int IDLE_CYCLES = slpc_pkg::IDLE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             force_active_input,
  output logic             force_shutdown_input,
  output logic             tx_logic_in_1,
  output logic             tx_logic_in_2,
  output logic             tx_logic_in_3,
  input  wire logic        rx_logic_out_1,
  input  wire logic        rx_logic_out_2,
  input  wire logic        rx_logic_out_3,
  input  wire logic        signal_detect
);
  localparam int CH = slpc_pkg::CHANNELS;

  logic [CH:0]   sync_q;
  logic [CH-1:0] rx_s;
  logic          det_s;

  slpc_sync #(.W(CH + 1)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({signal_detect, rx_logic_out_3, rx_logic_out_2, rx_logic_out_1}),
    .q       (sync_q)
  );
  assign rx_s  = sync_q[CH-1:0];
  assign det_s = sync_q[CH];

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:slpc_pkg::ADDR_LSB] == ofs[7:slpc_pkg::ADDR_LSB];
  endfunction : addr_is

  // APB slave: zero wait states
  logic access;
  logic mapped;
  logic wr_ctrl;
  logic wr_tx;

  assign access  = psel && penable;
  assign mapped  = addr_is(paddr, slpc_pkg::CTRL_OFS) || addr_is(paddr, slpc_pkg::TXDATA_OFS)
                   || addr_is(paddr, slpc_pkg::STATUS_OFS);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_ctrl = access && pwrite && addr_is(paddr, slpc_pkg::CTRL_OFS);
  assign wr_tx   = access && pwrite && addr_is(paddr, slpc_pkg::TXDATA_OFS);

  slpc_pkg::slpc_mode_e mode_reg, mode_next;
  logic [CH-1:0]        tx_reg, tx_next;
  logic [31:0]          wake_cnt_reg, wake_cnt_next;
  logic [31:0]          idle_cnt_reg, idle_cnt_next;
  logic                 idle_reg, idle_next;
  logic [CH-1:0]        rx_prev_reg, rx_prev_next;
  logic                 fon_next, foff_next;
  logic                 wake_busy;
  logic                 line_edge;

  assign wake_busy = wake_cnt_reg != '0;
  assign line_edge = (rx_s != rx_prev_reg) || wr_tx && (pwdata[CH-1:0] != tx_reg);

  always_comb begin
    mode_next     = mode_reg;
    tx_next       = tx_reg;
    wake_cnt_next = wake_cnt_reg;
    if (wr_ctrl) begin
      case (pwdata[slpc_pkg::MODE_LSB +: slpc_pkg::MODE_W])
        slpc_pkg::MODE_FORCED_OFF:  mode_next = slpc_pkg::MODE_FORCED_OFF;
        slpc_pkg::MODE_FORCED_ON:   mode_next = slpc_pkg::MODE_FORCED_ON;
        slpc_pkg::MODE_AUTO:        mode_next = slpc_pkg::MODE_AUTO;
        slpc_pkg::MODE_DETECT_ON:   mode_next = slpc_pkg::MODE_DETECT_ON;
        slpc_pkg::MODE_DETECT_BOTH: mode_next = slpc_pkg::MODE_DETECT_BOTH;
        // Unknown codes keep the mode so a stray write cannot wake the line
        default:                    mode_next = mode_reg;
      endcase
    end
    if (wr_tx) begin
      tx_next = pwdata[CH-1:0];
    end
    if (wr_ctrl && pwdata[slpc_pkg::WAKE_BIT]) begin
      wake_cnt_next = WAKE_CYCLES;
    end else if (wake_busy) begin
      wake_cnt_next = wake_cnt_reg - 32'h1;
    end
  end

  always_comb begin
    rx_prev_next = rx_s;
    if (line_edge) begin
      idle_cnt_next = '0;
      idle_next     = 1'b0;
    end else if (idle_cnt_reg >= IDLE_CYCLES - 1) begin
      idle_cnt_next = idle_cnt_reg;
      idle_next     = 1'b1;
    end else begin
      idle_cnt_next = idle_cnt_reg + 32'h1;
      idle_next     = idle_reg;
    end
  end

  // Force pin decode; the wake burst never lifts a forced-off mode
  always_comb begin
    case (mode_reg)
      slpc_pkg::MODE_FORCED_OFF: begin
        fon_next  = 1'b0;
        foff_next = 1'b0;
      end
      slpc_pkg::MODE_FORCED_ON: begin
        fon_next  = 1'b1;
        foff_next = 1'b1;
      end
      slpc_pkg::MODE_AUTO: begin
        fon_next  = wake_busy;
        foff_next = 1'b1;
      end
      slpc_pkg::MODE_DETECT_ON: begin
        fon_next  = det_s || wake_busy;
        foff_next = 1'b1;
      end
      slpc_pkg::MODE_DETECT_BOTH: begin
        fon_next  = det_s || wake_busy;
        foff_next = det_s || wake_busy;
      end
      default: begin
        fon_next  = 1'b0;
        foff_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg             <= slpc_pkg::MODE_RESET;
      tx_reg               <= '0;
      wake_cnt_reg         <= '0;
      idle_cnt_reg         <= '0;
      idle_reg             <= 1'b0;
      rx_prev_reg          <= '0;
      force_active_input   <= 1'b0;
      force_shutdown_input <= 1'b0;
    end else begin
      mode_reg             <= mode_next;
      tx_reg               <= tx_next;
      wake_cnt_reg         <= wake_cnt_next;
      idle_cnt_reg         <= idle_cnt_next;
      idle_reg             <= idle_next;
      rx_prev_reg          <= rx_prev_next;
      force_active_input   <= fon_next;
      force_shutdown_input <= foff_next;
    end
  end

  assign tx_logic_in_1 = tx_reg[0];
  assign tx_logic_in_2 = tx_reg[1];
  assign tx_logic_in_3 = tx_reg[2];

  always_comb begin
    prdata = '0;
    if (access && !pwrite) begin
      if (addr_is(paddr, slpc_pkg::CTRL_OFS)) begin
        prdata[slpc_pkg::MODE_LSB +: slpc_pkg::MODE_W] = mode_reg;
      end else if (addr_is(paddr, slpc_pkg::TXDATA_OFS)) begin
        prdata[CH-1:0] = tx_reg;
      end else if (addr_is(paddr, slpc_pkg::STATUS_OFS)) begin
        prdata[slpc_pkg::RX_LSB +: CH]  = rx_s;
        prdata[slpc_pkg::DET_BIT]   = det_s;
        prdata[slpc_pkg::WBUSY_BIT] = wake_busy;
        prdata[slpc_pkg::FON_BIT]   = force_active_input;
        prdata[slpc_pkg::FOFF_BIT]  = force_shutdown_input;
        prdata[slpc_pkg::IDLE_BIT]  = idle_reg;
      end
    end
  end

  // Assertions
  a_off_holds_low: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == slpc_pkg::MODE_FORCED_OFF) |=> !force_shutdown_input && !force_active_input)
    else $error("forced-off mode did not drive both force pins low");

  a_detect_ties_on: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == slpc_pkg::MODE_DETECT_ON && !wake_busy)
    |=> force_active_input == $past(det_s) && force_shutdown_input)
    else $error("force-on did not follow detect");

  a_detect_ties_both: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == slpc_pkg::MODE_DETECT_BOTH && !wake_busy)
    |=> force_active_input == $past(det_s) && force_shutdown_input == $past(det_s))
    else $error("force pins did not both follow detect");

  a_wake_burst_on: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_busy && mode_reg == slpc_pkg::MODE_AUTO) |=> force_active_input && force_shutdown_input)
    else $error("wake burst did not force transmitters on");

  a_wake_start_len: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[slpc_pkg::WAKE_BIT]) |=> wake_cnt_reg == WAKE_CYCLES)
    else $error("wake burst length wrong");

  a_tx_follows_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_tx |=> {tx_logic_in_3, tx_logic_in_2, tx_logic_in_1} == $past(pwdata[CH-1:0]))
    else $error("transmitter inputs did not take written value");

  a_edge_clears_idle: assert property (@(posedge pclk) disable iff (!presetn)
    line_edge |=> !idle_reg && idle_cnt_reg == '0)
    else $error("line edge did not restart inactivity timer");

  c_wake_in_auto: cover property (@(posedge pclk) disable iff (!presetn)
    mode_reg == slpc_pkg::MODE_AUTO && $rose(wake_busy));
  c_detect_drop: cover property (@(posedge pclk) disable iff (!presetn)
    mode_reg == slpc_pkg::MODE_DETECT_BOTH && $fell(force_shutdown_input));
  c_idle_reached: cover property (@(posedge pclk) disable iff (!presetn) $rose(idle_reg));
  c_bad_address: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : slpc_ctrl
`default_nettype wire

// *** design/slpc_pkg.sv ***
// Package for the serial line power controller: register map, fields, modes and timing.
// Assumes a 20 MHz pclk and a 32-bit APB register bus.
`default_nettype none
package slpc_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] TXDATA_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam int         ADDR_LSB   = 2;

  // CTRL fields
  localparam int MODE_LSB  = 0;
  localparam int MODE_W    = 3;
  localparam int WAKE_BIT  = 4;
  // STATUS fields
  localparam int RX_LSB    = 0;
  localparam int DET_BIT   = 3;
  localparam int WBUSY_BIT = 4;
  localparam int FON_BIT   = 5;
  localparam int FOFF_BIT  = 6;
  localparam int IDLE_BIT  = 7;

  localparam int CHANNELS = 3;

  typedef enum logic [2:0] {
    MODE_FORCED_OFF  = 3'h0,
    MODE_FORCED_ON   = 3'h1,
    MODE_AUTO        = 3'h2,
    MODE_DETECT_ON   = 3'h3,
    MODE_DETECT_BOTH = 3'h4
  } slpc_mode_e;

  localparam slpc_mode_e MODE_RESET = MODE_FORCED_OFF;

  // Timing
  localparam longint CLK_HZ      = 20000000;
  localparam longint WAKE_MS     = 100;
  localparam longint IDLE_S      = 30;
  localparam int     WAKE_CYCLES = int'(WAKE_MS * CLK_HZ / 1000);
  localparam int     IDLE_CYCLES = int'(IDLE_S * CLK_HZ);
  localparam int     CNT_W       = 32;
endpackage : slpc_pkg
`default_nettype wire

// *** design/slpc_sync.sv ***
// Two-flop synchroniser for a bus of independent level signals.
// Assumes each bit is a slow level; no multi-bit coherency is given.
`default_nettype none
module slpc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule : slpc_sync
`default_nettype wire

// *** dv/slpc_ctrl_test.sv ***
// Self-checking bench for the serial line power controller over APB.
// Assumes the transceiver model in slpc_xcvr_model and short wake and idle counts.
`default_nettype none
module slpc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fon, foff, det, det_in, pump;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [2:0]  tx, rx, rxl, lines;
  logic [32:0] exp_q[$], msk_q[$], m;
  int          fail_count, total_checks;
  localparam logic [32:0] MS = 33'h1_0000_007F;

  slpc_ctrl #(.WAKE_CYCLES(20), .IDLE_CYCLES(50)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .force_active_input(fon), .force_shutdown_input(foff), .tx_logic_in_1(tx[0]),
    .tx_logic_in_2(tx[1]), .tx_logic_in_3(tx[2]), .rx_logic_out_1(rxl[0]), .rx_logic_out_2(rxl[1]),
    .rx_logic_out_3(rxl[2]), .signal_detect(det));
  slpc_xcvr_model #(.IDLE(50)) dev (.pclk(pclk), .force_active_input(fon), .force_shutdown_input(foff),
    .tx_logic_in(tx), .rx_line_in(rx), .line_valid(det_in), .rx_logic_out(rxl), .signal_detect(det),
    .tx_line_out(lines), .pump_on(pump));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // Expected STATUS with force pins {off,on} per mode and the current detect level
  function automatic logic [32:0] stv(input int md, input logic d);
    logic [1:0] p;
    case (md)
      0: p = 2'b00;
      1: p = 2'b11;
      2: p = 2'b10;
      3: p = {1'b1, d};
      default: p = {d, d};
    endcase
    return {26'h0, p, 1'b0, d, rx};
  endfunction : stv

  task automatic end_of_test;
    $display("Checks %0d, errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    total_checks++;
    if (seen !== expv) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      end_of_test();
    end else begin
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] mk);
    exp_q.push_back(e & mk);
    msk_q.push_back(mk);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Read results are matched to the oldest note when the access completes
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1_FFFF_FFFF);
      else begin
        m = msk_q.pop_front();
        check({pslverr, prdata} & m, exp_q.pop_front());
      end
    end
  end

  initial begin
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    presetn      = 1'b0;
    rx           = 3'h5;
    det_in       = 1'b0;
    seed         = 32'h7CE36876;
    fail_count   = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(slpc_pkg::STATUS_OFS, stv(0, 1'b0), MS);
    // Mode 5 is refused, so the pins stay as mode 4 left them
    for (int d = 0; d < 2; d++) begin
      for (int md = 0; md < 6; md++) begin
        det_in <= d[0];
        apb(1'b1, slpc_pkg::CTRL_OFS, 32'(md));
        repeat (6) @(posedge pclk);
        rd(slpc_pkg::STATUS_OFS, stv(md, d[0]), MS);
      end
    end
    apb(1'b1, slpc_pkg::CTRL_OFS, 32'h10);
    repeat (3) @(posedge pclk);
    rd(slpc_pkg::STATUS_OFS, stv(0, 1'b1), 33'h1_0000_006F);
    apb(1'b1, slpc_pkg::CTRL_OFS, 32'h12);
    rd(slpc_pkg::STATUS_OFS, 33'h70, 33'h70);
    repeat (25) @(posedge pclk);
    rd(slpc_pkg::STATUS_OFS, stv(2, 1'b1), MS);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      apb(1'b1, slpc_pkg::TXDATA_OFS, seed);
      @(negedge pclk);
      check({30'h0, tx}, {30'h0, seed[2:0]});
    end
    repeat (60) @(posedge pclk);
    rd(slpc_pkg::STATUS_OFS, 33'h80, 33'h80);
    rx <= ~rx;
    repeat (5) @(posedge pclk);
    rd(slpc_pkg::STATUS_OFS, 33'h00, 33'h80);
    // A reset in mid-run must bring back forced-off with cleared registers
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(slpc_pkg::CTRL_OFS, 33'h0, MS);
    rd(slpc_pkg::TXDATA_OFS, 33'h0, MS);
    rd(slpc_pkg::STATUS_OFS, stv(0, 1'b1), MS);
    rd(8'h0C, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    // Let the monitor take the last read before the verdict
    repeat (2) @(posedge pclk);
    check(33'(exp_q.size()), 33'h0);
    end_of_test();
  end
endmodule : slpc_ctrl_test
`default_nettype wire

// *** dv/slpc_xcvr_model.sv ***
// Behavioural model of the three-channel line transceiver driven by the controller.
// Assumes it is clocked by the bench clock only to time inactivity and detect delays; it has no reset.
`default_nettype none
module slpc_xcvr_model #(
  parameter int IDLE     = 50,
  parameter int DET_RISE = 2,
  parameter int DET_FALL = 4
) (
  input  wire logic       pclk,
  input  wire logic       force_active_input,
  input  wire logic       force_shutdown_input,
  input  wire logic [2:0] tx_logic_in,
  input  wire logic [2:0] rx_line_in,
  input  wire logic       line_valid,
  output logic      [2:0] rx_logic_out,
  output logic            signal_detect,
  output logic      [2:0] tx_line_out,
  output logic            pump_on
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] last    = '0;
  int         cnt     = 0;
  logic       det_reg = 1'b0;
  int         det_cnt = 0;
  always @(posedge pclk) begin
    last <= {rx_line_in, tx_logic_in};
    if (last !== {rx_line_in, tx_logic_in}) cnt <= 0;
    else if (cnt < IDLE) cnt <= cnt + 1;
  end
  assign pump_on = force_shutdown_input && (force_active_input || cnt < IDLE);
  assign tx_line_out = pump_on ? ~tx_logic_in : 3'bZZZ;
  assign rx_logic_out = rx_line_in;
  // Detect settle delays
  // A level must hold for the whole delay; a shorter glitch restarts it
  always @(posedge pclk) begin
    if (line_valid == det_reg) begin
      det_cnt <= 0;
    end else if (det_cnt < (det_reg ? DET_FALL : DET_RISE) - 1) begin
      det_cnt <= det_cnt + 1;
    end else begin
      det_cnt <= 0;
      det_reg <= line_valid;
    end
  end
  assign signal_detect = det_reg;
endmodule : slpc_xcvr_model
`default_nettype wire
